// *** rtl/hpi_pkg.sv ***
// Summary of operation
// - Momentary request sets a sticky detail toggle.
// - Program tests, forces each detail toggle.
// - Active details raise readable subclass and class lines.
// - Class reset clears its constituent detail toggles.
// - Class reset reaches through subclasses down to every detail.
// - Master line puts processor into interrupt mode.
// - Master, class, subclass ignore toggles are programmable.
// - Ignore blocks upward only; signals stay testable.
// - Requests rise level by level until blocked.
// - Normal interrupts taken at instruction boundary only.
// - Entry sets master ignore toggle.
// - Entry stores memory transfer register to word zero.
// - Entry stores return address in word 14 high half.
// - Jump through class vector word.
// - Program error suspends within one clock.
// - Other computer errors stop at recoverable point.
// - Disc instruction transfer error counts as computer error.
// - Interrupt aborts search; search toggle untouched.
// - Fixed class priority chooses the vector.
// - Six consecutive vector words, high four characters.
// - No normal interrupt right after toggle instruction.
package hpi_pkg;
  localparam int NDET = 16;
  localparam int NCLS = 6;
  // Class numbering follows priority order, 0 highest.
  localparam int C_ERR  = 0;
  localparam int C_IO   = 1;
  localparam int C_DISC = 2;
  localparam int C_RT   = 3;
  localparam int C_UR   = 4;
  localparam int C_OTH  = 5;
  // Error class subclasses.
  localparam int S_CPU  = 0;
  localparam int S_XFER = 1;
  // Detail bit positions; computer error details first.
  localparam int D_PROG = 0;
  localparam int D_CERR = 1;
  localparam int D_DISC_INSTR = 2;
  localparam int D_XFER = 3;
  localparam logic [15:0] DET_CLASS_ERR  = 16'h000f;
  localparam logic [15:0] DET_CLASS_IO   = 16'h00f0;
  localparam logic [15:0] DET_CLASS_DISC = 16'h0700;
  localparam logic [15:0] DET_CLASS_RT   = 16'h1800;
  localparam logic [15:0] DET_CLASS_UR   = 16'h6000;
  localparam logic [15:0] DET_CLASS_OTH  = 16'h8000;
  localparam logic [15:0] DET_SUB_CPU    = 16'h0007;
  localparam logic [15:0] DET_SUB_XFER   = 16'h0008;
  // Memory words used on entry.
  localparam logic [15:0] ADR_SAVE_R   = 16'h0000;
  localparam logic [15:0] ADR_SAVE_RET = 16'h000e;
  localparam logic [15:0] ADR_VEC_BASE = 16'h0008;
  // Vector word offset per priority-ordered class.
  localparam logic [15:0] VEC_OFS_ERR  = 16'h0002;
  localparam logic [15:0] VEC_OFS_IO   = 16'h0003;
  localparam logic [15:0] VEC_OFS_DISC = 16'h0001;
  localparam logic [15:0] VEC_OFS_RT   = 16'h0004;
  localparam logic [15:0] VEC_OFS_UR   = 16'h0000;
  localparam logic [15:0] VEC_OFS_OTH  = 16'h0005;
  // Register map.
  localparam logic [7:0] REG_DET    = 8'h00;
  localparam logic [7:0] REG_DSET   = 8'h04;
  localparam logic [7:0] REG_DCLR   = 8'h08;
  localparam logic [7:0] REG_IGN    = 8'h0c;
  localparam logic [7:0] REG_CRST   = 8'h10;
  localparam logic [7:0] REG_STAT   = 8'h14;
  localparam logic [8:0] IGN_RST    = 9'h1ff;
  localparam int IGN_MASTER = 8;
  localparam int IGN_SUB0   = 6;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum logic [2:0] {
    ST_RUN, ST_SAVE_R, ST_SAVE_RET, ST_VEC, ST_JUMP
  } hpi_state_t;
endpackage

// *** rtl/hpi_unit.sv ***
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module hpi_unit
  import hpi_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [NDET-1:0]  det_req,
  input  wire logic             instr_boundary,
  input  wire logic             recover_point,
  input  wire logic             toggle_instr_done,
  input  wire logic             search_active,
  input  wire logic [15:0]      mtr_data,
  input  wire logic [15:0]      instr_addr,
  output logic                  int_mode,
  output logic                  suspend,
  output logic                  search_abort,
  output logic                  mem_wr,
  output logic                  mem_rd,
  output logic [15:0]           mem_addr,
  output logic [15:0]           mem_wdata,
  output logic                  mem_hi_half,
  input  wire logic [15:0]      mem_rdata,
  input  wire logic             mem_ack,
  output logic                  jump_valid,
  output logic [15:0]           jump_addr,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  logic [NDET-1:0] det_ff;
  logic [8:0]      ign_ff;
  logic [NCLS-1:0] cls_line;
  logic [1:0]      sub_line;
  logic [NCLS-1:0] cls_pass;
  logic            master_line;
  logic            fresh_toggle_ff;
  logic            prog_err;
  logic            cerr_any;
  hpi_state_t      state_ff;
  logic [15:0]     vec_ofs_ff;
  logic [15:0]     jump_addr_ff;
  logic            jump_valid_ff;
  logic [15:0]     ret_addr_ff;
  logic [15:0]     mtr_ff;
  logic [15:0]     cls_mask [NCLS];
  logic [15:0]     vec_ofs [NCLS];

  logic [7:0]      aw_ff;
  logic [31:0]     w_ff;
  logic [3:0]      ws_ff;
  logic            awv_ff;
  logic            wv_ff;
  logic            bv_ff;
  logic [1:0]      br_ff;
  logic            rv_ff;
  logic [31:0]     rd_ff;
  logic [1:0]      rr_ff;
  logic            wr_go;
  logic            wr_map;
  logic [15:0]     wd16;
  logic            entry_go;

  assign cls_mask[C_ERR]  = DET_CLASS_ERR;
  assign cls_mask[C_IO]   = DET_CLASS_IO;
  assign cls_mask[C_DISC] = DET_CLASS_DISC;
  assign cls_mask[C_RT]   = DET_CLASS_RT;
  assign cls_mask[C_UR]   = DET_CLASS_UR;
  assign cls_mask[C_OTH]  = DET_CLASS_OTH;
  assign vec_ofs[C_ERR]   = VEC_OFS_ERR;
  assign vec_ofs[C_IO]    = VEC_OFS_IO;
  assign vec_ofs[C_DISC]  = VEC_OFS_DISC;
  assign vec_ofs[C_RT]    = VEC_OFS_RT;
  assign vec_ofs[C_UR]    = VEC_OFS_UR;
  assign vec_ofs[C_OTH]   = VEC_OFS_OTH;

  // Subclass lines feed the error class through their own ignores.
  assign sub_line[S_CPU]  = |(det_ff & DET_SUB_CPU);
  assign sub_line[S_XFER] = |(det_ff & DET_SUB_XFER);

  genvar gi;
  generate
    for (gi = 0; gi < NCLS; gi++) begin : g_cls
      if (gi == C_ERR) begin : g_err
        assign cls_line[gi] = |sub_line;
        assign cls_pass[gi] = ~ign_ff[gi] &
          |(sub_line & ~ign_ff[IGN_SUB0+1:IGN_SUB0]);
      end else begin : g_plain
        assign cls_line[gi] = |(det_ff & cls_mask[gi]);
        assign cls_pass[gi] = cls_line[gi] & ~ign_ff[gi];
      end
    end
  endgenerate

  assign master_line = |cls_pass & ~ign_ff[IGN_MASTER];
  // Disc instruction transfer errors sit in the computer subclass.
  assign prog_err = det_ff[D_PROG] & cls_pass[C_ERR] &
                    ~ign_ff[IGN_SUB0+S_CPU];
  assign cerr_any = |(det_ff & DET_SUB_CPU) & cls_pass[C_ERR] &
                    ~ign_ff[IGN_SUB0+S_CPU];

  // Entry timing: program error at once, other computer errors at a
  // recoverable point or a boundary, all else at a boundary not after a toggle op.
  always_comb begin
    entry_go = 1'b0;
    if (master_line && state_ff == ST_RUN) begin
      if (prog_err) begin
        entry_go = 1'b1;
      end else if (cerr_any) begin
        entry_go = recover_point | instr_boundary;
      end else begin
        entry_go = instr_boundary & ~fresh_toggle_ff;
      end
    end
  end

  assign wr_go  = awv_ff & wv_ff & ~bv_ff;
  assign wr_map = aw_ff == REG_DET || aw_ff == REG_DSET ||
                  aw_ff == REG_DCLR || aw_ff == REG_IGN ||
                  aw_ff == REG_CRST || aw_ff == REG_STAT;
  assign wd16   = s_wd(w_ff, ws_ff);

  function automatic logic [15:0] s_wd(input logic [31:0] d,
                                       input logic [3:0] s);
    s_wd = {d[15:8] & {8{s[1]}}, d[7:0] & {8{s[0]}}};
  endfunction

  // Detail toggles: hardware set wins over any clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_ff <= '0;
    end else begin
      logic [NDET-1:0] clr;
      logic [NDET-1:0] nxt_det;
      clr = '0;
      nxt_det = det_ff;
      if (wr_go && aw_ff == REG_DET) begin
        nxt_det = wd16;
      end
      if (wr_go && aw_ff == REG_DSET) begin
        nxt_det = nxt_det | wd16;
      end
      if (wr_go && aw_ff == REG_DCLR) begin
        clr = wd16;
      end
      if (wr_go && aw_ff == REG_CRST) begin
        for (int c = 0; c < NCLS; c++) begin
          if (w_ff[c]) begin
            clr = clr | cls_mask[c];
          end
        end
        if (w_ff[8+S_CPU]) clr = clr | DET_SUB_CPU;
        if (w_ff[8+S_XFER]) clr = clr | DET_SUB_XFER;
      end
      det_ff <= (nxt_det & ~clr) | det_req;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ign_ff <= IGN_RST;
    end else if (entry_go) begin
      ign_ff[IGN_MASTER] <= 1'b1;
    end else if (wr_go && aw_ff == REG_IGN) begin
      ign_ff <= wd16[8:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fresh_toggle_ff <= 1'b0;
    end else if (toggle_instr_done) begin
      fresh_toggle_ff <= 1'b1;
    end else if (instr_boundary) begin
      fresh_toggle_ff <= 1'b0;
    end
  end

  // Entry sequence: save R, save return address, fetch vector, jump.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= ST_RUN;
      vec_ofs_ff    <= '0;
      ret_addr_ff   <= '0;
      mtr_ff        <= '0;
      jump_addr_ff  <= '0;
      jump_valid_ff <= 1'b0;
    end else begin
      jump_valid_ff <= 1'b0;
      case (state_ff)
        ST_RUN: begin
          if (entry_go) begin
            state_ff    <= ST_SAVE_R;
            mtr_ff      <= mtr_data;
            ret_addr_ff <= instr_addr;
            vec_ofs_ff  <= VEC_OFS_OTH;
            for (int c = NCLS - 1; c >= 0; c--) begin
              if (cls_pass[c]) vec_ofs_ff <= vec_ofs[c];
            end
          end
        end
        ST_SAVE_R: begin
          if (mem_ack) state_ff <= ST_SAVE_RET;
        end
        ST_SAVE_RET: begin
          if (mem_ack) state_ff <= ST_VEC;
        end
        ST_VEC: begin
          if (mem_ack) begin
            jump_addr_ff <= mem_rdata;
            state_ff     <= ST_JUMP;
          end
        end
        ST_JUMP: begin
          jump_valid_ff <= 1'b1;
          state_ff      <= ST_RUN;
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  assign int_mode     = state_ff != ST_RUN;
  assign suspend      = entry_go | int_mode;
  // Only the abort pulse; the search mode toggle lives elsewhere.
  assign search_abort = entry_go & search_active;
  assign mem_wr       = state_ff == ST_SAVE_R || state_ff == ST_SAVE_RET;
  assign mem_rd       = state_ff == ST_VEC;
  assign mem_hi_half  = state_ff != ST_SAVE_R;
  assign mem_addr  = state_ff == ST_SAVE_R   ? ADR_SAVE_R :
                     state_ff == ST_SAVE_RET ? ADR_SAVE_RET :
                     ADR_VEC_BASE + vec_ofs_ff;
  assign mem_wdata = state_ff == ST_SAVE_R ? mtr_ff : ret_addr_ff;
  assign jump_addr  = jump_addr_ff;
  assign jump_valid = jump_valid_ff;

  // AXI4-Lite write path: address and data captured independently.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awv_ff <= 1'b0;
      wv_ff  <= 1'b0;
      aw_ff  <= '0;
      w_ff   <= '0;
      ws_ff  <= '0;
      bv_ff  <= 1'b0;
      br_ff  <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awv_ff <= 1'b1;
        aw_ff  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wv_ff <= 1'b1;
        w_ff  <= s_axi_wdata;
        ws_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        awv_ff <= 1'b0;
        wv_ff  <= 1'b0;
        bv_ff  <= 1'b1;
        br_ff  <= wr_map ? RESP_OK : RESP_ERR;
      end else if (bv_ff && s_axi_bready) begin
        bv_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~awv_ff & ~bv_ff;
  assign s_axi_wready  = ~wv_ff & ~bv_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_ff <= 1'b0;
      rd_ff <= '0;
      rr_ff <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rv_ff <= 1'b1;
      rr_ff <= RESP_OK;
      case ({s_axi_araddr[7:2], 2'b00})
        REG_DET:  rd_ff <= {16'h0000, det_ff};
        REG_IGN:  rd_ff <= {23'h00_0000, ign_ff};
        REG_STAT: rd_ff <= {18'h0_0000,
                            state_ff != ST_RUN, master_line, sub_line,
                            4'h0, cls_line};
        REG_DSET, REG_DCLR, REG_CRST: rd_ff <= '0;
        default: begin
          rd_ff <= '0;
          rr_ff <= RESP_ERR;
        end
      endcase
    end else if (rv_ff && s_axi_rready) begin
      rv_ff <= 1'b0;
    end
  end

  assign s_axi_arready = ~rv_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;

  a_det_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    det_req[4] |=> det_ff[4]) else $error("detail lost");
  a_master_ign: assert property (@(posedge aclk) disable iff (!aresetn)
    entry_go |=> ign_ff[IGN_MASTER]) else $error("no ignore");
  a_no_entry_ign: assert property (@(posedge aclk) disable iff (!aresetn)
    ign_ff[IGN_MASTER] |-> !entry_go) else $error("ignored");
  a_prog_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    (prog_err && !ign_ff[IGN_MASTER] && state_ff == ST_RUN)
      |-> entry_go) else $error("slow error");
  a_no_fresh: assert property (@(posedge aclk) disable iff (!aresetn)
    (entry_go && !cerr_any && !prog_err) |-> !fresh_toggle_ff)
    else $error("toggle gap");
  a_save_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    entry_go |=> mem_wr && mem_addr == ADR_SAVE_R)
    else $error("save r");
  a_err_prio: assert property (@(posedge aclk) disable iff (!aresetn)
    (entry_go && cls_pass[C_ERR]) |=> vec_ofs_ff == VEC_OFS_ERR)
    else $error("priority");
  a_class_line: assert property (@(posedge aclk) disable iff (!aresetn)
    det_ff[8] |-> cls_line[C_DISC]) else $error("class");
  a_boundary: assert property (@(posedge aclk) disable iff (!aresetn)
    (entry_go && !cerr_any && !prog_err) |-> instr_boundary)
    else $error("mid instr");
  a_ret_save: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_SAVE_RET) |-> (mem_wr && mem_hi_half &&
      mem_addr == ADR_SAVE_RET)) else $error("save return");
  a_vec_half: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_rd |-> mem_hi_half) else $error("vector half");
endmodule // hpi_unit

// *** sim/hpi_proc_model.sv ***
`timescale 1ns/1ns
module hpi_proc_model (
  input  wire logic        aclk,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        mem_hi_half,
  input  wire logic [1:0]  lat,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack
);
  logic [15:0] mem_ff [32];
  logic        hi_ff  [32];
  logic [15:0] rd_ff;
  logic [1:0]  cnt_ff;
  logic        ack_ff;
  // Each vector word carries its own index, so every class is told apart.
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem_ff[i] = 16'ha000 | 16'(i);
      hi_ff[i] = 1'b0;
    end
    rd_ff = 16'h0000;
    cnt_ff = 2'b00;
    ack_ff = 1'b0;
  end
  always @(posedge aclk) begin
    ack_ff <= 1'b0;
    if ((mem_wr || mem_rd) && !ack_ff) begin
      if (cnt_ff == lat) begin
        ack_ff <= 1'b1;
        cnt_ff <= 2'b00;
        rd_ff <= mem_ff[mem_addr[4:0]];
        if (mem_wr) begin
          mem_ff[mem_addr[4:0]] <= mem_wdata;
          hi_ff[mem_addr[4:0]] <= mem_hi_half;
        end
      end else begin
        cnt_ff <= cnt_ff + 2'b01;
      end
    end
  end
  // Outside an acknowledge the data lines never show a stale word.
  assign mem_ack = ack_ff;
  assign mem_rdata = ack_ff ? rd_ff : ~rd_ff;
endmodule // hpi_proc_model

// *** sim/tb_hpi_unit.sv ***
`timescale 1ns/1ns
module tb_hpi_unit;
  import hpi_pkg::*;
  logic            aclk, aresetn, instr_boundary, recover_point;
  logic            toggle_instr_done, search_active, int_mode, suspend;
  logic            search_abort, mem_wr, mem_rd, mem_hi_half, mem_ack;
  logic            jump_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic            s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic            s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic            seen_int, seen_abort, seen_susp;
  logic [NDET-1:0] det_req;
  logic [15:0]     mtr_data, instr_addr, mem_addr, mem_wdata, mem_rdata;
  logic [15:0]     jump_addr, jaddr;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp, resp, lat;
  int              err_total, checks_done, cyc, jcnt, n;
  int              det_bit [6] = '{3, 4, 8, 11, 13, 15};
  logic [15:0]     vofs [6] = '{VEC_OFS_ERR, VEC_OFS_IO, VEC_OFS_DISC,
                                VEC_OFS_RT, VEC_OFS_UR, VEC_OFS_OTH};

  hpi_unit u_hpi_unit (.aclk(aclk), .aresetn(aresetn), .det_req(det_req),
    .instr_boundary(instr_boundary), .recover_point(recover_point),
    .toggle_instr_done(toggle_instr_done), .search_active(search_active),
    .mtr_data(mtr_data), .instr_addr(instr_addr), .int_mode(int_mode),
    .suspend(suspend), .search_abort(search_abort), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_hi_half(mem_hi_half), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .jump_valid(jump_valid), .jump_addr(jump_addr),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  hpi_proc_model u_hpi_proc_model (.aclk(aclk), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_hi_half(mem_hi_half), .lat(lat), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_h(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t half %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Each transfer starts one edge late so no strobe is set twice at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk_w(rv, exp);
  endtask
  task automatic wait_jump;
    int m;
    m = jcnt;
    while (jcnt == m) @(posedge aclk);
  endtask
  function automatic logic [15:0] vec(input logic [15:0] ofs);
    return 16'ha000 | (ADR_VEC_BASE + ofs);
  endfunction

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (int_mode === 1'b1) seen_int <= 1'b1;
    if (search_abort === 1'b1) seen_abort <= 1'b1;
    if (suspend === 1'b1) seen_susp <= 1'b1;
    if (jump_valid === 1'b1) begin
      jaddr <= jump_addr;
      jcnt <= jcnt + 1;
    end
    if (cyc == 20000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      stop_test;
    end
  end

  initial begin
    {aresetn, recover_point, toggle_instr_done, search_active} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, seen_int, seen_abort, seen_susp} = 5'h00;
    instr_boundary = 1'b1;
    det_req = '0;
    {mtr_data, instr_addr, jaddr} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    lat = 2'b00;
    {err_total, checks_done, cyc, jcnt, n} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(REG_IGN, 32'h0000_01ff);
    rdchk(REG_DET, 32'h0000_0000);
    @(posedge aclk);
    det_req <= 16'h0010;
    @(posedge aclk);
    det_req <= '0;
    rdchk(REG_DET, 32'h0000_0010);
    rdchk(REG_STAT, 32'h0000_0002);
    wr(REG_DSET, 32'h0000_0108);
    rdchk(REG_DET, 32'h0000_0118);
    rdchk(REG_STAT, 32'h0000_0807);
    wr(REG_CRST, 32'h0000_0002);
    rdchk(REG_DET, 32'h0000_0108);
    wr(REG_CRST, 32'h0000_0200);
    rdchk(REG_DET, 32'h0000_0100);
    wr(REG_DCLR, 32'h0000_0100);
    rdchk(REG_DET, 32'h0000_0000);
    rd(8'h40);
    chk_h(16'(resp), 16'(RESP_ERR));
    wr(8'h40, 32'h0000_ffff);
    chk_h(16'(resp), 16'(RESP_ERR));
    wr(REG_IGN, 32'h0000_0155);
    rdchk(REG_IGN, 32'h0000_0155);
    // One entry per class, partner latency cycling 0 to 3, then back to 0 and 1.
    for (int c = 0; c < NCLS; c++) begin
      lat <= c[1:0];
      mtr_data <= 16'h5a00 + 16'(c);
      instr_addr <= 16'h3c00 + 16'(c);
      wr(REG_DSET, 32'h0000_0001 << det_bit[c]);
      wr(REG_IGN, 32'h0000_0000);
      wait_jump;
      chk_h(jaddr, vec(vofs[c]));
      chk_h(u_hpi_proc_model.mem_ff[0], 16'h5a00 + 16'(c));
      chk_h(16'(u_hpi_proc_model.hi_ff[0]), 16'h0000);
      chk_h(u_hpi_proc_model.mem_ff[14], 16'h3c00 + 16'(c));
      chk_h(16'(u_hpi_proc_model.hi_ff[14]), 16'h0001);
      rdchk(REG_IGN, 32'h0000_0100);
      wr(REG_CRST, 32'h0000_0001 << c);
    end
    chk_h(16'(seen_int), 16'h0001);
    chk_h(16'(seen_susp), 16'h0001);
    wr(REG_DSET, 32'h0000_8110);
    wr(REG_IGN, 32'h0000_0000);
    wait_jump;
    chk_h(jaddr, vec(VEC_OFS_IO));
    wr(REG_CRST, 32'h0000_003f);
    instr_boundary <= 1'b0;
    wr(REG_DSET, 32'h0000_0010);
    toggle_instr_done <= 1'b1;
    @(posedge aclk);
    toggle_instr_done <= 1'b0;
    n = jcnt;
    wr(REG_IGN, 32'h0000_0000);
    repeat (6) @(posedge aclk);
    chk_h(16'(jcnt - n), 16'h0000);
    instr_boundary <= 1'b1;
    @(posedge aclk);
    instr_boundary <= 1'b0;
    repeat (6) @(posedge aclk);
    chk_h(16'(jcnt - n), 16'h0000);
    instr_boundary <= 1'b1;
    wait_jump;
    chk_h(jaddr, vec(VEC_OFS_IO));
    wr(REG_CRST, 32'h0000_003f);
    instr_boundary <= 1'b0;
    search_active <= 1'b1;
    wr(REG_DSET, 32'h0000_0001);
    wr(REG_IGN, 32'h0000_0000);
    wait_jump;
    chk_h(jaddr, vec(VEC_OFS_ERR));
    chk_h(16'(seen_abort), 16'h0001);
    wr(REG_CRST, 32'h0000_003f);
    search_active <= 1'b0;
    recover_point <= 1'b1;
    wr(REG_DSET, 32'h0000_0004);
    wr(REG_IGN, 32'h0000_0000);
    wait_jump;
    chk_h(jaddr, vec(VEC_OFS_ERR));
    stop_test;
  end
endmodule // tb_hpi_unit
